// file: rtl/msq_pkg.sv
package msq_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_NS = 100;

    // widths
    localparam int CNT_W = 24;
    localparam int RATE_W = 16;
    localparam int RATE_SHIFT = 8;
    localparam int REV_RATE_SHIFT = 4;

    // time units
    localparam int unsigned BRAKE_UNIT_US = 100000;
    localparam int unsigned ALIGN_UNIT_US = 40000;
    localparam int unsigned ISD_UNIT_US = 10000;
    localparam int unsigned REV_BASE_US = 1000;
    localparam int unsigned ACCEL_TICK_US = 1000;
    localparam int unsigned IPD_MAX_US = 2000;
    localparam int unsigned IPD_GAP_US = 100;

    // least times, rounded up to whole cycles
    localparam int unsigned BRAKE_UNIT_CYC = (BRAKE_UNIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ALIGN_UNIT_CYC = (ALIGN_UNIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ISD_UNIT_CYC = (ISD_UNIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REV_BASE_CYC = (REV_BASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACCEL_TICK_CYC = (ACCEL_TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IPD_MAX_CYC = (IPD_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IPD_GAP_CYC = (IPD_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // reset values
    localparam logic [RATE_W-1:0] RATE_RST = 16'h0000;
    localparam logic [2:0] SECTOR_RST = 3'h0;
    localparam logic [2:0] ALIGN_START_SECTOR = 3'h3;

    // position sensing pair order: VW WV UV VU WU UW
    localparam logic [2:0] PAIR_VW = 3'h0;
    localparam logic [2:0] PAIR_UW = 3'h5;

    // forward commutation sector of each pair
    localparam logic [2:0] PAIR_TO_SECTOR [6] = '{3'h2, 3'h5, 3'h0, 3'h3, 3'h4, 3'h1};
    // pair driven in each forward sector
    localparam logic [2:0] SECTOR_TO_PAIR [6] = '{3'h2, 3'h5, 3'h0, 3'h3, 3'h4, 3'h1};

    typedef enum logic [3:0] {
        ST_POWER_ON    = 4'b0000,
        ST_SPEED_SENSE = 4'b0001,
        ST_BRAKE_CHECK = 4'b0010,
        ST_RESYNC      = 4'b0011,
        ST_REV_DRIVE   = 4'b0100,
        ST_BRAKE       = 4'b0101,
        ST_POS_CHECK   = 4'b0110,
        ST_POS_SENSE   = 4'b0111,
        ST_ALIGN       = 4'b1000,
        ST_ACCEL       = 4'b1001,
        ST_CLOSED      = 4'b1010
    } msq_state_t;

endpackage

// file: rtl/msq_timer.sv
`timescale 1ns/1ns
module msq_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [msq_pkg::CNT_W-1:0] loadValue,
    // status
    output logic expired
);

    logic [msq_pkg::CNT_W-1:0] count_r;
    logic [msq_pkg::CNT_W-1:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = loadValue;
        end else if (count_r != '0) begin
            count_nxt = count_r - msq_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign expired = (count_r == '0);

endmodule

// file: rtl/msq_speed_sense.sv
`timescale 1ns/1ns
module msq_speed_sense (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic restart,
    input wire logic [msq_pkg::CNT_W-1:0] timeoutCyc,
    // comparators
    input wire logic cmpUv,
    input wire logic cmpUw,
    // result
    output logic done,
    output logic stationary,
    output logic reverse,
    output logic [msq_pkg::CNT_W-1:0] period,
    output logic [2:0] sector
);

    logic prevUv_r, prevUv_nxt;
    logic prevUw_r, prevUw_nxt;
    logic [msq_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [msq_pkg::CNT_W-1:0] period_r, period_nxt;
    logic [1:0] edges_r, edges_nxt;
    logic dirKnown_r, dirKnown_nxt;
    logic reverse_r, reverse_nxt;
    logic stationary_r, stationary_nxt;
    logic riseUv, riseAny;

    always_comb begin
        riseUv = cmpUv && !prevUv_r;
        riseAny = riseUv || (cmpUw && !prevUw_r);
        prevUv_nxt = cmpUv;
        prevUw_nxt = cmpUw;
        cnt_nxt = cnt_r;
        period_nxt = period_r;
        edges_nxt = edges_r;
        dirKnown_nxt = dirKnown_r;
        reverse_nxt = reverse_r;
        stationary_nxt = stationary_r;
        if (restart) begin
            cnt_nxt = '0;
            edges_nxt = 2'h0;
            dirKnown_nxt = 1'b0;
            stationary_nxt = 1'b0;
        end else if (!done) begin
            if (riseAny) begin
                // time between successive rising edges of either comparator
                cnt_nxt = msq_pkg::CNT_W'(1);
                if (edges_r != 2'h0) begin
                    period_nxt = cnt_r;
                end
                if (edges_r != 2'h2) begin
                    edges_nxt = edges_r + 2'h1;
                end
            end else if (cnt_r >= timeoutCyc) begin
                stationary_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + msq_pkg::CNT_W'(1);
            end
            if (riseUv) begin
                // uw already high at uv rise means uw leads: reverse
                reverse_nxt = cmpUw;
                dirKnown_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prevUv_r <= 1'b0;
            prevUw_r <= 1'b0;
            cnt_r <= '0;
            period_r <= '0;
            edges_r <= 2'h0;
            dirKnown_r <= 1'b0;
            reverse_r <= 1'b0;
            stationary_r <= 1'b0;
        end else begin
            prevUv_r <= prevUv_nxt;
            prevUw_r <= prevUw_nxt;
            cnt_r <= cnt_nxt;
            period_r <= period_nxt;
            edges_r <= edges_nxt;
            dirKnown_r <= dirKnown_nxt;
            reverse_r <= reverse_nxt;
            stationary_r <= stationary_nxt;
        end
    end

    assign done = stationary_r || (edges_r == 2'h2 && dirKnown_r);
    assign stationary = stationary_r;
    assign reverse = reverse_r;
    assign period = period_r;
    assign sector = {1'b0, prevUv_r, prevUw_r};

endmodule

// file: rtl/msq_start_sequencer.sv
`timescale 1ns/1ns
module msq_start_sequencer #(
    parameter int unsigned BRAKE_UNIT_CYC = msq_pkg::BRAKE_UNIT_CYC,
    parameter int unsigned ALIGN_UNIT_CYC = msq_pkg::ALIGN_UNIT_CYC,
    parameter int unsigned ISD_UNIT_CYC = msq_pkg::ISD_UNIT_CYC,
    parameter int unsigned REV_BASE_CYC = msq_pkg::REV_BASE_CYC,
    parameter int unsigned ACCEL_TICK_CYC = msq_pkg::ACCEL_TICK_CYC,
    parameter int unsigned IPD_MAX_CYC = msq_pkg::IPD_MAX_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // power state
    input wire logic wakeEvent,
    // configuration
    input wire logic speedSensingEnable,
    input wire logic [1:0] stationaryThreshold,
    input wire logic [2:0] reverseDriveSpeedLimit,
    input wire logic reverseDriveEnable,
    input wire logic [2:0] brakeDuration,
    input wire logic [3:0] positionSensingCurrentLimit,
    input wire logic [2:0] alignmentDuration,
    input wire logic [2:0] firstOrderAccel,
    input wire logic [2:0] secondOrderAccel,
    input wire logic [4:0] handoffSpeedThreshold,
    // motor feedback
    input wire logic dirIn,
    input wire logic cmpUv,
    input wire logic cmpUw,
    input wire logic ipdCurrentReached,
    // closed loop algorithm
    input wire logic [2:0] algHighSide,
    input wire logic [2:0] algLowSide,
    // phase drive, bit 0 U, bit 1 V, bit 2 W
    output logic [2:0] highSideOn,
    output logic [2:0] lowSideOn,
    // status
    output logic [3:0] seqState,
    output logic [2:0] openLoopSector,
    output logic [15:0] openLoopRate,
    output logic resyncLoad,
    output logic [2:0] resyncSector,
    output logic [23:0] resyncPeriod,
    output logic [2:0] ipdSector
);

    localparam int CW = msq_pkg::CNT_W;
    localparam int RW = msq_pkg::RATE_W;

    msq_pkg::msq_state_t state_r, state_nxt;
    logic dir_r, dir_nxt;
    logic [RW-1:0] rate_r, rate_nxt;
    logic [RW-1:0] accel2_r, accel2_nxt;
    logic [RW-1:0] phaseAcc_r, phaseAcc_nxt;
    logic [2:0] sector_r, sector_nxt;
    logic [2:0] ipdPair_r, ipdPair_nxt;
    logic ipdRelease_r, ipdRelease_nxt;
    logic [CW-1:0] ipdTime_r, ipdTime_nxt;
    logic [CW-1:0] ipdBest_r, ipdBest_nxt;
    logic [2:0] ipdBestIdx_r, ipdBestIdx_nxt;
    logic [2:0] hs_r, hs_nxt;
    logic [2:0] ls_r, ls_nxt;
    logic resyncLoad_r, resyncLoad_nxt;
    logic [2:0] resyncSector_r, resyncSector_nxt;
    logic [CW-1:0] resyncPeriod_r, resyncPeriod_nxt;

    logic senseRestart, senseDone, senseStationary, senseReverse;
    logic [CW-1:0] sensePeriod;
    logic [2:0] senseSector;
    logic durLoad, durExpired, tickExpired;
    logic [CW-1:0] durValue;
    logic [RW-1:0] accelStep, accel2Step;
    logic [RW:0] phaseSum, rateSum;
    logic [2:0] sectorInc;
    logic [5:0] pairPat;

    function automatic logic [5:0] pairDrive(input logic [2:0] pair);
        logic [5:0] pat;
        pat = 6'b000000;
        case (pair)
            3'h0: pat = 6'b010100;
            3'h1: pat = 6'b100010;
            3'h2: pat = 6'b001010;
            3'h3: pat = 6'b010001;
            3'h4: pat = 6'b100001;
            3'h5: pat = 6'b001100;
            default: pat = 6'b000000;
        endcase
        return pat;
    endfunction

    msq_speed_sense u_sense (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .restart(senseRestart),
        .timeoutCyc(CW'(ISD_UNIT_CYC << stationaryThreshold)),
        .cmpUv(cmpUv),
        .cmpUw(cmpUw),
        .done(senseDone),
        .stationary(senseStationary),
        .reverse(senseReverse),
        .period(sensePeriod),
        .sector(senseSector)
    );

    msq_timer u_dur (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(durLoad),
        .loadValue(durValue),
        .expired(durExpired)
    );

    msq_timer u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(tickExpired),
        .loadValue(CW'(ACCEL_TICK_CYC - 1)),
        .expired(tickExpired)
    );

    always_comb begin
        state_nxt = state_r;
        dir_nxt = dirIn;
        rate_nxt = rate_r;
        accel2_nxt = accel2_r;
        phaseAcc_nxt = phaseAcc_r;
        sector_nxt = sector_r;
        ipdPair_nxt = ipdPair_r;
        ipdRelease_nxt = ipdRelease_r;
        ipdTime_nxt = ipdTime_r;
        ipdBest_nxt = ipdBest_r;
        ipdBestIdx_nxt = ipdBestIdx_r;
        hs_nxt = 3'h0;
        ls_nxt = 3'h0;
        resyncLoad_nxt = 1'b0;
        resyncSector_nxt = resyncSector_r;
        resyncPeriod_nxt = resyncPeriod_r;
        senseRestart = 1'b0;
        durLoad = 1'b0;
        durValue = '0;
        accel2Step = accel2_r + RW'(secondOrderAccel);
        accelStep = RW'(firstOrderAccel) + accel2Step;
        phaseSum = {1'b0, phaseAcc_r} + {1'b0, rate_r};
        rateSum = {1'b0, rate_r} + {1'b0, accelStep};
        sectorInc = (sector_r == 3'h5) ? 3'h0 : sector_r + 3'h1;
        pairPat = pairDrive(msq_pkg::SECTOR_TO_PAIR[sector_r]);
        case (state_r)
            msq_pkg::ST_POWER_ON: begin
                rate_nxt = msq_pkg::RATE_RST;
                accel2_nxt = '0;
                phaseAcc_nxt = '0;
                sector_nxt = msq_pkg::SECTOR_RST;
                if (speedSensingEnable) begin
                    state_nxt = msq_pkg::ST_SPEED_SENSE;
                    senseRestart = 1'b1;
                end else begin
                    state_nxt = msq_pkg::ST_BRAKE_CHECK;
                end
            end
            msq_pkg::ST_SPEED_SENSE: begin
                // phases stay off while coasting
                if (senseDone) begin
                    if (senseStationary) begin
                        state_nxt = msq_pkg::ST_BRAKE_CHECK;
                    end else if (!senseReverse) begin
                        state_nxt = msq_pkg::ST_RESYNC;
                        resyncLoad_nxt = 1'b1;
                        resyncSector_nxt = senseSector;
                        resyncPeriod_nxt = sensePeriod;
                    end else if (sensePeriod < CW'(REV_BASE_CYC >> reverseDriveSpeedLimit)) begin
                        senseRestart = 1'b1;
                    end else if (reverseDriveEnable) begin
                        state_nxt = msq_pkg::ST_REV_DRIVE;
                        rate_nxt = (RW'(reverseDriveSpeedLimit) + RW'(1)) << msq_pkg::REV_RATE_SHIFT;
                    end else begin
                        state_nxt = msq_pkg::ST_BRAKE_CHECK;
                    end
                end
            end
            msq_pkg::ST_RESYNC: begin
                state_nxt = msq_pkg::ST_CLOSED;
            end
            msq_pkg::ST_REV_DRIVE: begin
                hs_nxt = pairPat[5:3];
                ls_nxt = pairPat[2:0];
                if (tickExpired) begin
                    accel2_nxt = accel2Step;
                    phaseAcc_nxt = phaseSum[RW-1:0];
                    if (phaseSum[RW]) begin
                        sector_nxt = sectorInc;
                    end
                    if (rate_r <= accelStep) begin
                        // through zero, keep accelerating
                        rate_nxt = RW'(accelStep - rate_r);
                        state_nxt = msq_pkg::ST_ACCEL;
                    end else begin
                        rate_nxt = rate_r - accelStep;
                    end
                end
            end
            msq_pkg::ST_BRAKE_CHECK: begin
                if (brakeDuration != 3'h0) begin
                    state_nxt = msq_pkg::ST_BRAKE;
                    durLoad = 1'b1;
                    durValue = CW'(BRAKE_UNIT_CYC * brakeDuration);
                end else begin
                    state_nxt = msq_pkg::ST_POS_CHECK;
                end
            end
            msq_pkg::ST_BRAKE: begin
                ls_nxt = 3'b111;
                if (durExpired) begin
                    state_nxt = msq_pkg::ST_POS_CHECK;
                end
            end
            msq_pkg::ST_POS_CHECK: begin
                if (positionSensingCurrentLimit != 4'h0) begin
                    state_nxt = msq_pkg::ST_POS_SENSE;
                    ipdPair_nxt = msq_pkg::PAIR_VW;
                    ipdRelease_nxt = 1'b0;
                    ipdTime_nxt = '0;
                    ipdBest_nxt = '1;
                    ipdBestIdx_nxt = msq_pkg::PAIR_VW;
                end else begin
                    state_nxt = msq_pkg::ST_ALIGN;
                    durLoad = 1'b1;
                    durValue = CW'(ALIGN_UNIT_CYC * (alignmentDuration + 3'h1));
                end
            end
            msq_pkg::ST_ALIGN: begin
                hs_nxt = 3'b010;
                ls_nxt = 3'b100;
                if (durExpired) begin
                    state_nxt = msq_pkg::ST_ACCEL;
                    sector_nxt = msq_pkg::ALIGN_START_SECTOR;
                end
            end
            msq_pkg::ST_POS_SENSE: begin
                ipdTime_nxt = ipdTime_r + CW'(1);
                if (!ipdRelease_r) begin
                    {hs_nxt, ls_nxt} = pairDrive(ipdPair_r);
                    if (ipdCurrentReached || ipdTime_r >= CW'(IPD_MAX_CYC)) begin
                        hs_nxt = 3'h0;
                        ls_nxt = 3'h0;
                        ipdRelease_nxt = 1'b1;
                        ipdTime_nxt = '0;
                        if (ipdTime_r < ipdBest_r) begin
                            ipdBest_nxt = ipdTime_r;
                            ipdBestIdx_nxt = ipdPair_r;
                        end
                    end
                end else if (ipdTime_r >= CW'(msq_pkg::IPD_GAP_CYC)) begin
                    if (ipdPair_r == msq_pkg::PAIR_UW) begin
                        state_nxt = msq_pkg::ST_ACCEL;
                        sector_nxt = (msq_pkg::PAIR_TO_SECTOR[ipdBestIdx_r] == 3'h5) ? 3'h0 :
                            msq_pkg::PAIR_TO_SECTOR[ipdBestIdx_r] + 3'h1;
                    end else begin
                        ipdPair_nxt = ipdPair_r + 3'h1;
                        ipdRelease_nxt = 1'b0;
                        ipdTime_nxt = '0;
                    end
                end
            end
            msq_pkg::ST_ACCEL: begin
                hs_nxt = pairPat[5:3];
                ls_nxt = pairPat[2:0];
                if (rate_r > (RW'(handoffSpeedThreshold) << msq_pkg::RATE_SHIFT)) begin
                    state_nxt = msq_pkg::ST_CLOSED;
                end else if (tickExpired) begin
                    accel2_nxt = accel2Step;
                    rate_nxt = rateSum[RW] ? '1 : rateSum[RW-1:0];
                    phaseAcc_nxt = phaseSum[RW-1:0];
                    if (phaseSum[RW]) begin
                        sector_nxt = sectorInc;
                    end
                end
            end
            msq_pkg::ST_CLOSED: begin
                hs_nxt = algHighSide;
                ls_nxt = algLowSide;
            end
            default: begin
                state_nxt = msq_pkg::ST_POWER_ON;
            end
        endcase
        if (wakeEvent || dirIn != dir_r) begin
            state_nxt = msq_pkg::ST_POWER_ON;
            hs_nxt = 3'h0;
            ls_nxt = 3'h0;
            senseRestart = 1'b0;
            durLoad = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= msq_pkg::ST_POWER_ON;
            dir_r <= 1'b0;
            rate_r <= msq_pkg::RATE_RST;
            accel2_r <= '0;
            phaseAcc_r <= '0;
            sector_r <= msq_pkg::SECTOR_RST;
            ipdPair_r <= msq_pkg::PAIR_VW;
            ipdRelease_r <= 1'b0;
            ipdTime_r <= '0;
            ipdBest_r <= '1;
            ipdBestIdx_r <= msq_pkg::PAIR_VW;
            hs_r <= 3'h0;
            ls_r <= 3'h0;
            resyncLoad_r <= 1'b0;
            resyncSector_r <= 3'h0;
            resyncPeriod_r <= '0;
        end else begin
            state_r <= state_nxt;
            dir_r <= dir_nxt;
            rate_r <= rate_nxt;
            accel2_r <= accel2_nxt;
            phaseAcc_r <= phaseAcc_nxt;
            sector_r <= sector_nxt;
            ipdPair_r <= ipdPair_nxt;
            ipdRelease_r <= ipdRelease_nxt;
            ipdTime_r <= ipdTime_nxt;
            ipdBest_r <= ipdBest_nxt;
            ipdBestIdx_r <= ipdBestIdx_nxt;
            hs_r <= hs_nxt;
            ls_r <= ls_nxt;
            resyncLoad_r <= resyncLoad_nxt;
            resyncSector_r <= resyncSector_nxt;
            resyncPeriod_r <= resyncPeriod_nxt;
        end
    end

    assign highSideOn = hs_r;
    assign lowSideOn = ls_r;
    assign seqState = state_r;
    assign openLoopSector = sector_r;
    assign openLoopRate = rate_r;
    assign resyncLoad = resyncLoad_r;
    assign resyncSector = resyncSector_r;
    assign resyncPeriod = resyncPeriod_r;
    assign ipdSector = ipdBestIdx_r;

endmodule

// file: testbench/msq_checker.sv
`timescale 1ns/1ns
module msq_checker (
    // watched ports
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wakeEvent,
    input wire logic dirIn,
    input wire logic speedSensingEnable,
    input wire logic [2:0] brakeDuration,
    input wire logic [2:0] highSideOn,
    input wire logic [2:0] lowSideOn,
    input wire logic [3:0] seqState,
    input wire logic resyncLoad
);
    logic dirPrev_r;
    wire steady = !wakeEvent && dirPrev_r == dirIn;
    always_ff @(posedge clk_sys) dirPrev_r <= rst_n & dirIn;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_resync; seqState == 4'h3 ##1 seqState == 4'hA; endsequence
    chk_power_branch: assert property (seqState == 4'h0 && steady |=>
        seqState == ($past(speedSensingEnable) ? 4'h1 : 4'h2)) else $error("power branch");
    chk_brake_branch: assert property (seqState == 4'h2 && steady |=>
        seqState == ($past(brakeDuration) != 3'h0 ? 4'h5 : 4'h6)) else $error("brake branch");
    chk_dir_restart: assert property (dirPrev_r != dirIn |=>
        seqState == 4'h0 && {highSideOn, lowSideOn} == 6'h00) else $error("dir restart");
    chk_wake_restart: assert property (wakeEvent |=> seqState == 4'h0)
        else $error("wake restart");
    chk_brake_low: assert property (seqState == 4'h5 && $past(seqState) == 4'h5 |->
        {highSideOn, lowSideOn} == 6'h07) else $error("brake drive");
    chk_align_drive: assert property (seqState == 4'h8 && $past(seqState) == 4'h8 |->
        {highSideOn, lowSideOn} == 6'h14) else $error("align drive");
    chk_sense_hiz: assert property (seqState == 4'h1 |->
        {highSideOn, lowSideOn} == 6'h00) else $error("sense drive");
    chk_resync_seq: assert property (resyncLoad && steady |-> s_resync)
        else $error("resync");
endmodule
bind msq_start_sequencer msq_checker u_chk (.clk_sys, .rst_n, .wakeEvent, .dirIn,
    .speedSensingEnable, .brakeDuration, .highSideOn, .lowSideOn, .seqState, .resyncLoad);

// file: testbench/msq_motor_model.sv
`timescale 1ns/1ns
module msq_motor_model (
    // clock, motion (0 still, 1 forward, 2 reverse), drive and sensing
    input wire logic clk_sys,
    input wire logic [1:0] spin,
    input wire logic [2:0] highSideOn,
    input wire logic [2:0] lowSideOn,
    output logic cmpUv,
    output logic cmpUw,
    output logic ipdCurrentReached
);
    int ph_r = 0, cnt_r = 0;
    // uw trails uv by a sixth of a turn forward, leads it in reverse
    assign cmpUv = ph_r < 48;
    assign cmpUw = (ph_r + (spin == 2'h2 ? 16 : 80)) % 96 < 48;
    // the uv pair is least inductive, so its current rises first
    assign ipdCurrentReached =
        cnt_r > (highSideOn == 3'h1 && lowSideOn == 3'h2 ? 4 : 8);
    always @(posedge clk_sys) begin
        ph_r <= spin == 2'h0 ? ph_r : (ph_r + 1) % 96;
        cnt_r <= highSideOn != 3'h0 && lowSideOn != 3'h0 ? cnt_r + 1 : 0;
    end
endmodule

// file: testbench/tb_msq_start_sequencer.sv
`timescale 1ns/1ns
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin errors++; \
    $display("BAD %s exp %0h got %0h", n, e, v); end end
module tb_msq_start_sequencer;
    logic clk_sys = 0, rst_n = 0, wakeEvent = 0, speedSensingEnable = 0, dirIn = 0;
    logic cmpUv, cmpUw, ipdCurrentReached, resyncLoad;
    logic [1:0] stationaryThreshold = 2'h3, spin = 2'h0;
    logic [2:0] brakeDuration = 3'h0, alignmentDuration = 3'h0, algHighSide = 3'h0;
    logic [2:0] algLowSide = 3'h0, highSideOn, lowSideOn, ipdSector;
    logic [3:0] positionSensingCurrentLimit = 4'h0, seqState;
    logic reverseDriveEnable = 0;
    logic [2:0] reverseDriveSpeedLimit = 3'h0, firstOrderAccel = 3'h7, secondOrderAccel = 3'h7;
    logic [2:0] openLoopSector, resyncSector;
    logic [4:0] handoffSpeedThreshold = 5'h01;
    logic [15:0] openLoopRate;
    logic [23:0] resyncPeriod;
    int errors = 0, comparisons = 0, seed = 65, i, t;
    always #50 clk_sys = ~clk_sys;
    msq_start_sequencer #(.BRAKE_UNIT_CYC(20), .ALIGN_UNIT_CYC(20), .ISD_UNIT_CYC(50),
        .REV_BASE_CYC(64), .ACCEL_TICK_CYC(4)) dut (.clk_sys, .rst_n,
        .wakeEvent, .speedSensingEnable, .stationaryThreshold, .reverseDriveSpeedLimit,
        .reverseDriveEnable, .brakeDuration, .positionSensingCurrentLimit,
        .alignmentDuration, .firstOrderAccel, .secondOrderAccel,
        .handoffSpeedThreshold, .dirIn, .cmpUv, .cmpUw, .ipdCurrentReached,
        .algHighSide, .algLowSide, .highSideOn, .lowSideOn, .seqState, .openLoopSector,
        .openLoopRate, .resyncLoad, .resyncSector, .resyncPeriod, .ipdSector);
    msq_motor_model motor (.clk_sys, .spin, .highSideOn, .lowSideOn, .cmpUv, .cmpUw,
        .ipdCurrentReached);
    function automatic int brakeCycles(input logic [2:0] code);
        return 20 * code;
    endfunction
    function automatic int revRate(input logic [2:0] code);
        return (int'(code) + 1) << msq_pkg::REV_RATE_SHIFT;
    endfunction
    function automatic int handoff(input logic [4:0] code);
        return int'(code) << msq_pkg::RATE_SHIFT;
    endfunction
    // forward model: uw rises 16 cycles after uv, uv 80 cycles after uw
    function automatic int lastGap(input logic uwHigh);
        return uwHigh ? 16 : 80;
    endfunction
    task automatic waitUvRise();
        int n, m;
        for (n = 0; n < 200 && cmpUv !== 1'b0; n++) @(negedge clk_sys);
        for (m = 0; m < 200 && cmpUv !== 1'b1; m++) @(negedge clk_sys);
        if (n == 200 || m == 200) summarize(1);
    endtask
    task automatic summarize(input int hung);
        errors += hung;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic waitSt(input logic [3:0] st);
        int n;
        for (n = 0; n < 9000 && seqState !== st; n++) @(negedge clk_sys);
        if (n == 9000) summarize(1);
    endtask
    task automatic restart();
        wakeEvent = 1;
        @(negedge clk_sys);
        `CHK("wake", 4'h0, seqState)
        wakeEvent = 0;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1;
        alignmentDuration = 3'($random(seed));
        firstOrderAccel = 3'($random(seed));
        waitSt(4'h8);
        waitSt(4'h9);
        `CHK("align sector", msq_pkg::ALIGN_START_SECTOR, openLoopSector)
        waitSt(4'hA);
        `CHK("handoff", 1'b1, openLoopRate > handoff(handoffSpeedThreshold))
        for (i = 0; i < 16; i++) begin
            {algHighSide, algLowSide} = 6'($random(seed));
            @(negedge clk_sys);
            `CHK("closed drive", {algHighSide, algLowSide}, {highSideOn, lowSideOn})
        end
        brakeDuration = 3'($random(seed)) | 3'h1;
        dirIn = 1;
        @(negedge clk_sys);
        `CHK("dir restart", 4'h0, seqState)
        waitSt(4'h5);
        for (i = 0; i < 200 && seqState === 4'h5; i++) @(negedge clk_sys);
        t = brakeCycles(brakeDuration);
        `CHK("brake len", 1'b1, i + 3 >= t && i <= t + 2)
        `CHK("after brake", 4'h6, seqState)
        $display("drive test done");
        brakeDuration = 3'h0;
        speedSensingEnable = 1;
        stationaryThreshold = 2'($random(seed)) | 2'h1;
        positionSensingCurrentLimit = 4'($random(seed)) | 4'h1;
        restart();
        waitSt(4'h1);
        waitSt(4'h2);
        waitSt(4'h9);
        `CHK("best pair", 3'h2, ipdSector)
        `CHK("ipd sector", msq_pkg::PAIR_TO_SECTOR[2] + 3'h1, openLoopSector)
        spin = 2'h1;
        restart();
        waitSt(4'h3);
        `CHK("resync pulse", 1'b1, resyncLoad)
        `CHK("resync sector", {1'b0, cmpUv, cmpUw}, resyncSector)
        `CHK("resync period", lastGap(cmpUw), resyncPeriod)
        @(negedge clk_sys);
        `CHK("resync closed", 4'hA, seqState)
        $display("sensing test done");
        reverseDriveEnable = 1;
        spin = 2'h2;
        waitUvRise();
        restart();
        repeat (300) @(negedge clk_sys);
        `CHK("rev too fast", 4'h1, seqState)
        reverseDriveSpeedLimit = 3'h3;
        waitSt(4'h4);
        `CHK("rev rate", revRate(reverseDriveSpeedLimit), openLoopRate)
        waitSt(4'h9);
        waitSt(4'hA);
        $display("reverse test done");
        summarize(0);
    end
endmodule
